//--- tb/acs_datapath_properties.sv
/* Bus and completion checker for acs_datapath.
   Assumes it is bound to the datapath and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
`include "acs_defs.vh"
module acs_props (
  input wire aclk,
  input wire aresetn,
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire op_done
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_aw_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write channel ready while response pending");
  chk_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address ready while read data pending");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write response late");
  chk_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  chk_r_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data repeated");
  chk_cmd_done: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready && s_axi_awaddr == `ACS_OFF_CMD |-> ##[1:3] op_done) else $error("no done");
  chk_done_pulse: assert property (op_done |=> !op_done)
    else $error("done longer than one cycle");
endmodule // acs_props
bind acs_datapath acs_props u_props (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .op_done(op_done));
`default_nettype wire

//--- tb/tb_add_carry_shift_operand_datapath.sv
/* Self-checking bench for acs_datapath over AXI4-Lite.
   Assumes acs_defs.vh on the include path. */
`timescale 1ns/1ps
`default_nettype none
`include "acs_defs.vh"
module tb_add_carry_shift_operand_datapath;
  logic aclk = 0, aresetn = 0;
  logic [11:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  wire awready, wready, bvalid, arready, rvalid, op_done;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  integer errors = 0, checks = 0, tn = 0, seed = 32'hdc1d116f, i;
  logic [15:0] r;
  always #20 aclk = ~aclk;
  acs_datapath dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .op_done(op_done));
  task automatic cmp(input [33:0] got, input [33:0] exp);
    checks = checks + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Responses are judged here, in issue order
  always @(posedge aclk) begin
    if (rvalid && rready) cmp({rresp, rdata}, rq.pop_front());
    if (bvalid && bready) cmp({32'h0, bresp}, {32'h0, bq.pop_front()});
  end
  task automatic wr(input [11:0] a, input [31:0] d, input [1:0] e = 0);
    bq.push_back(e);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (!bvalid);
    bready <= 0;
  endtask
  task automatic rd(input [11:0] a, input [31:0] e, input [1:0] s = 0);
    rq.push_back({s, e});
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 0;
    end while (!rvalid);
    rready <= 0;
  endtask
  task automatic ww(input [3:0] n, input [15:0] d);
    wr({`ACS_WORK_BASE, n, 2'h0}, {16'h0, d});
  endtask
  task automatic rw(input [3:0] n, input [15:0] e);
    rd({`ACS_WORK_BASE, n, 2'h0}, {16'h0, e});
  endtask
  task automatic wm(input [5:0] k, input [15:0] d);
    wr({`ACS_MEM_BASE, k, 2'h0}, {16'h0, d});
  endtask
  task automatic ex(input [4:0] op, input [3:0] d, s, b, input t, input [5:0] f,
    input [1:0] sm, input [31:0] st);
    wr(`ACS_OFF_STAT, st);
    wr(`ACS_OFF_CMD, {3'h0, f, 2'h0, sm, 1'b0, t, b, s, d, op});
  endtask
  task automatic fin_t;
    tn = tn + 1;
    $display("test %0d done", tn);
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #200000;
    errors = errors + 1;
    test_done;
  end
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1;
    rd(`ACS_OFF_STAT, 32'h0);
    for (i = 0; i < 16; i++) begin
      r = 16'($random(seed));
      ww(i[3:0], r);
      rw(i[3:0], r);
    end
    fin_t;
    ww(3, 16'hFC00);
    wr(`ACS_OFF_OPND, 32'h3FF);
    ex(`ACS_CADD_LIT, 3, 0, 0, 0, 0, 0, 32'h1);
    rw(3, 16'h0000);
    rd(`ACS_OFF_STAT, 32'h13);
    wm(5, 16'h7FFF);
    ww(0, 16'h0000);
    ex(`ACS_CADD_F, 0, 0, 0, 1, 5, 0, 32'h1);
    rw(0, 16'h8000);
    rd({`ACS_MEM_BASE, 6'd5, 2'h0}, 32'h7FFF);
    rd(`ACS_OFF_STAT, 32'h0E);
    fin_t;
    wm(6, 16'h8001);
    ex(`ACS_ASR_F, 0, 0, 0, 0, 6, 0, 32'h0A);
    rd({`ACS_MEM_BASE, 6'd6, 2'h0}, 32'hC000);
    rw(0, 16'h8000);
    rd(`ACS_OFF_STAT, 32'h07);
    ww(2, 16'h0204);
    wm(2, 16'h0002);
    ex(`ACS_ASR_W, 9, 2, 0, 0, 0, `ACS_AM_POSTINC, 32'h1F);
    rw(9, 16'h0001);
    rw(2, 16'h0206);
    rd(`ACS_OFF_STAT, 32'h02);
    ww(1, 16'h8000);
    ww(2, 16'h00F3);
    ex(`ACS_ASR_M, 3, 2, 1, 0, 0, 0, 32'h09);
    rw(3, 16'hF000);
    rd(`ACS_OFF_STAT, 32'h0D);
    fin_t;
    ww(4, 16'hF0F0);
    ww(5, 16'h0F0F);
    ex(`ACS_AND_W, 10, 5, 4, 0, 0, 0, 32'h0B);
    rw(10, 16'h0000);
    rd(`ACS_OFF_STAT, 32'h1B);
    wr(`ACS_OFF_OPND, 32'h0);
    ex(`ACS_ADD_ACC, 0, 5, 0, 0, 0, 0, 32'h1F);
    rd(`ACS_OFF_STAT, 32'h1F);
    rd(`ACS_OFF_ACCA_LO, 32'h0F0F0000);
    wr(`ACS_OFF_OPND, 32'h1000);
    ex(`ACS_ADD_ACC, 0, 1, 0, 0, 0, 0, 32'h0);
    rd(`ACS_OFF_ACCA_LO, 32'h070F0000);
    rd(`ACS_OFF_ACCA_HI, 32'h0);
    wr(`ACS_OFF_ACCB_HI, 32'h7F);
    wr(`ACS_OFF_ACCB_LO, 32'hFFFFFFFF);
    wr(`ACS_OFF_OPND, 32'h80000000);
    wr(`ACS_OFF_STAT, 32'h0);
    wr(`ACS_OFF_CMD, 32'h00040A04);
    rd(`ACS_OFF_STAT, 32'hA00);
    rd(`ACS_OFF_ACCB_HI, 32'h7F);
    rd(`ACS_OFF_ACCB_LO, 32'hFFFFFFFF);
    fin_t;
    ww(6, 16'h0064);
    ww(7, 16'h0007);
    ex(`ACS_DIV, 0, 7, 6, 0, 0, 0, 32'h0);
    rw(0, 16'h000E);
    rw(1, 16'h0002);
    wr(`ACS_OFF_OPND, 32'h40000);
    ex(`ACS_SQR, 0, 0, 0, 0, 0, 0, 32'h0);
    rd(`ACS_OFF_PROD, 32'h2710);
    ww(8, 16'h0102);
    ww(11, 16'h0108);
    wm(1, 16'h1234);
    wm(4, 16'h5678);
    ww(7, 16'h0007);
    wr(`ACS_OFF_OPND, 32'h5A914000);
    ex(`ACS_MPY, 0, 0, 0, 0, 0, 0, 32'h0);
    rd(`ACS_OFF_PROD, 32'h2BC);
    rw(5, 16'h1234);
    rw(8, 16'h0104);
    rw(6, 16'h5678);
    rw(11, 16'h0106);
    ex(`ACS_CADD_W, 12, 4, 7, 0, 0, 0, 32'h1);
    rw(12, 16'hF0F8);
    rd(`ACS_OFF_STAT, 32'h04);
    rd(12'h020, 32'h0, `ACS_RESP_SLVERR);
    wr(`ACS_OFF_PROD, 32'h1, `ACS_RESP_SLVERR);
    fin_t;
    @(posedge aclk);
    test_done;
  end
endmodule // tb_add_carry_shift_operand_datapath
`default_nettype wire

//--- verilog/acs_adder.v
/*
  Adder with carry in, giving carry, digit carry and signed overflow.
  Purely combinational; the caller registers the results.
*/
`timescale 1ns/1ps
`default_nettype none
module acs_adder #(
  parameter W = 16
) (
  input wire [W-1:0] a,
  input wire [W-1:0] b,
  input wire cin,
  output wire [W-1:0] sum,
  output wire carry,
  output wire digit_carry_flag,
  output wire overflow_flag
);
  wire [W:0] full;
  wire [4:0] low;

  assign full = {1'b0, a} + {1'b0, b} + {{W{1'b0}}, cin};
  assign low = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
  assign sum = full[W-1:0];
  assign carry = full[W];
  // Carry out of the low nibble
  assign digit_carry_flag = low[4];
  assign overflow_flag = (a[W-1] == b[W-1]) && (sum[W-1] != a[W-1]);
endmodule // acs_adder
`default_nettype wire

//--- verilog/acs_datapath.v
/*
  Operand datapath: working registers, data words, status flags, two
  accumulators, add-with-carry, AND, arithmetic shifts, multiply, square,
  divide and X/Y prefetch, driven by a command written over AXI4-Lite.
  Assumes one AXI4-Lite master with 12-bit addresses, single clock aclk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "acs_defs.vh"
module acs_datapath (
  input wire aclk,
  input wire aresetn,
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg op_done
);
  reg [15:0] w_q [0:15];
  reg [15:0] mem_q [0:63];
  reg [31:0] cmd_q;
  reg [31:0] opnd_q;
  reg [4:0] mcu_q;
  reg [3:0] dsp_q;
  reg [39:0] acca_q;
  reg [39:0] accb_q;
  reg [31:0] prod_q;
  reg exec_q;
  reg have_aw_q;
  reg have_w_q;
  reg [11:0] aw_addr_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;
  integer i;

  function [31:0] acs_merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0] strb;
    integer k;
    begin
      for (k = 0; k < 4; k = k + 1) begin
        acs_merge[k*8 +: 8] = strb[k] ? new_v[k*8 +: 8] : old_v[k*8 +: 8];
      end
    end
  endfunction

  function [15:0] acs_amod;
    input [1:0] mode;
    input [15:0] v;
    begin
      case (mode)
        `ACS_AM_POSTINC: acs_amod = v + `ACS_WORD_STEP;
        `ACS_AM_POSTDEC: acs_amod = v - `ACS_WORD_STEP;
        default: acs_amod = v;
      endcase
    end
  endfunction

  function [15:0] acs_pf_step;
    input [2:0] m;
    begin
      case (m)
        3'h2: acs_pf_step = `ACS_PF_P2;
        3'h3: acs_pf_step = `ACS_PF_P4;
        3'h4: acs_pf_step = `ACS_PF_P6;
        3'h5: acs_pf_step = `ACS_PF_M2;
        3'h6: acs_pf_step = `ACS_PF_M4;
        3'h7: acs_pf_step = `ACS_PF_M6;
        default: acs_pf_step = 16'h0000;
      endcase
    end
  endfunction

  // Command and operand fields
  wire [4:0] op = cmd_q[`ACS_CMD_OP];
  wire [3:0] dst_i = cmd_q[`ACS_CMD_DST];
  wire [3:0] src_i = cmd_q[`ACS_CMD_SRC];
  wire [3:0] bas_i = cmd_q[`ACS_CMD_BASE];
  wire to_w0 = cmd_q[`ACS_CMD_TOW0];
  wire acc_b = cmd_q[`ACS_CMD_ACCB];
  wire [1:0] smode = cmd_q[`ACS_CMD_SMODE];
  wire [1:0] dmode = cmd_q[`ACS_CMD_DMODE];
  wire [5:0] f_i = cmd_q[`ACS_CMD_F];
  wire [9:0] ten_bit_literal = opnd_q[`ACS_OP_LIT];
  wire [3:0] signed_shift_literal = opnd_q[`ACS_OP_SHIFT];
  wire [2:0] pair = opnd_q[`ACS_OP_PAIR];
  wire [1:0] sqr = opnd_q[`ACS_OP_SQR];
  wire [3:0] xmode = opnd_q[`ACS_OP_XMODE];
  wire [3:0] ymode = opnd_q[`ACS_OP_YMODE];
  wire [1:0] xd = opnd_q[`ACS_OP_XD];
  wire [1:0] yd = opnd_q[`ACS_OP_YD];
  wire sat_en = opnd_q[`ACS_OP_SATEN];

  // Operand fetch; any register may be base, source or destination
  wire [15:0] f_val = mem_q[f_i];
  wire [15:0] file_op_accumulator_reg = w_q[`ACS_W_Q];
  wire [15:0] base_work_reg = w_q[bas_i];
  wire [15:0] src_ptr = w_q[src_i];
  wire [15:0] src_work_reg = (smode == `ACS_AM_DIRECT) ? src_ptr : mem_q[src_ptr[`ACS_WIDX]];
  wire [15:0] dest_ptr = w_q[dst_i];

  reg [15:0] a_op;
  reg [15:0] b_op;
  always @* begin
    case (op)
      `ACS_CADD_F, `ACS_AND_F: begin
        a_op = f_val;
        b_op = file_op_accumulator_reg;
      end
      `ACS_CADD_LIT, `ACS_AND_LIT: begin
        a_op = dest_ptr;
        b_op = {6'h00, ten_bit_literal};
      end
      `ACS_CADD_W, `ACS_AND_W: begin
        a_op = base_work_reg;
        b_op = src_work_reg;
      end
      default: begin
        a_op = 16'h0000;
        b_op = 16'h0000;
      end
    endcase
  end

  wire [15:0] add_sum;
  wire add_c;
  wire add_dc;
  wire add_ov;
  acs_adder #(.W(16)) u_add (
    .a(a_op),
    .b(b_op),
    .cin(mcu_q[`ACS_FL_C]),
    .sum(add_sum),
    .carry(add_c),
    .digit_carry_flag(add_dc),
    .overflow_flag(add_ov)
  );

  // Shifts: single bit keeps the sign and moves bit 0 into carry
  wire [15:0] asr_src = (op == `ACS_ASR_F) ? f_val : src_work_reg;
  wire [15:0] asr_one = {asr_src[15], asr_src[15:1]};
  wire [15:0] asr_multi = $signed(base_work_reg) >>> src_ptr[`ACS_SHCNT];

  // Result and flag selection; every form here is one cycle
  reg [15:0] res;
  reg [4:0] fl_new;
  reg [4:0] fl_mask;
  always @* begin
    res = 16'h0000;
    fl_mask = `ACS_FM_NONE;
    fl_new = 5'h00;
    case (op)
      `ACS_CADD_F, `ACS_CADD_LIT, `ACS_CADD_W: begin
        res = add_sum;
        fl_mask = `ACS_FM_ALL;
        fl_new[`ACS_FL_C] = add_c;
        fl_new[`ACS_FL_DC] = add_dc;
        fl_new[`ACS_FL_OV] = add_ov;
      end
      `ACS_AND_F, `ACS_AND_LIT, `ACS_AND_W: begin
        res = a_op & b_op;
        fl_mask = `ACS_FM_NZ;
      end
      `ACS_ASR_F, `ACS_ASR_W: begin
        res = asr_one;
        fl_mask = `ACS_FM_ASR;
        fl_new[`ACS_FL_C] = asr_src[0];
      end
      `ACS_ASR_M: begin
        res = asr_multi;
        fl_mask = `ACS_FM_NZ;
      end
      default: begin
        res = 16'h0000;
      end
    endcase
    fl_new[`ACS_FL_N] = res[15];
    fl_new[`ACS_FL_Z] = (res == 16'h0000);
  end

  // Accumulator add: positive shift literal shifts right, negative left
  wire [39:0] acc_cur = acc_b ? accb_q : acca_q;
  wire [39:0] wso_ext = {{8{src_work_reg[15]}}, src_work_reg, 16'h0000};
  wire [3:0] sh_left = 4'h0 - signed_shift_literal;
  // Kept apart so the right shift stays signed; a mixed ?: would make it logical
  wire [39:0] wso_rsh = $signed(wso_ext) >>> signed_shift_literal;
  wire [39:0] wso_sh = signed_shift_literal[3] ? (wso_ext << sh_left) : wso_rsh;
  wire [40:0] acc_sum = {acc_cur[39], acc_cur} + {wso_sh[39], wso_sh};
  wire acc_ovf = acc_sum[40] ^ acc_sum[39];
  // Saturation only clamps a true 40-bit wrap; guard-bit use is reported by overflow
  wire [39:0] acc_res = (sat_en && acc_ovf) ?
                        (acc_sum[40] ? `ACS_ACC_MIN : `ACS_ACC_MAX) : acc_sum[39:0];
  wire acc_oa = ~((&acc_res[39:31]) | ~(|acc_res[39:31]));

  // Multiply operand pairs; codes 6 and 7 name no pair and do nothing
  reg [3:0] m_i;
  reg [3:0] n_i;
  reg pair_ok;
  always @* begin
    pair_ok = 1'b1;
    m_i = {`ACS_MUL_HI, sqr};
    n_i = {`ACS_MUL_HI, sqr};
    if (op == `ACS_MPY) begin
      case (pair)
        3'h0: begin m_i = 4'h4; n_i = 4'h5; end
        3'h1: begin m_i = 4'h4; n_i = 4'h6; end
        3'h2: begin m_i = 4'h4; n_i = 4'h7; end
        3'h3: begin m_i = 4'h5; n_i = 4'h6; end
        3'h4: begin m_i = 4'h5; n_i = 4'h7; end
        3'h5: begin m_i = 4'h6; n_i = 4'h7; end
        default: begin pair_ok = 1'b0; end
      endcase
    end
  end
  wire [31:0] prod = $signed(w_q[m_i]) * $signed(w_q[n_i]);

  // X and Y prefetch: mode 0 on the low pointer means none, on the high one indexed
  wire [3:0] x_ptr_i = xmode[3] ? `ACS_W_X1 : `ACS_W_X0;
  wire x_indexed = (xmode[2:0] == 3'h0);
  wire x_on = xmode[3] | ~x_indexed;
  wire [15:0] x_addr = x_indexed ? (w_q[`ACS_W_X1] + w_q[`ACS_W_IDX]) : w_q[x_ptr_i];
  wire [15:0] x_next = w_q[x_ptr_i] + acs_pf_step(xmode[2:0]);
  wire [15:0] x_data = mem_q[x_addr[`ACS_WIDX]];
  wire [3:0] y_ptr_i = ymode[3] ? `ACS_W_Y1 : `ACS_W_Y0;
  wire y_indexed = (ymode[2:0] == 3'h0);
  wire y_on = ymode[3] | ~y_indexed;
  wire [15:0] y_addr = y_indexed ? (w_q[`ACS_W_Y1] + w_q[`ACS_W_IDX]) : w_q[y_ptr_i];
  wire [15:0] y_next = w_q[y_ptr_i] + acs_pf_step(ymode[2:0]);
  wire [15:0] y_data = mem_q[y_addr[`ACS_WIDX]];

  // Divide, direct registers only; divide by zero gives an all-ones quotient and the dividend as remainder
  wire dv_zero = (src_ptr == 16'h0000);
  wire [15:0] dv_q = dv_zero ? `ACS_DIV0_Q : (base_work_reg / src_ptr);
  wire [15:0] dv_r = dv_zero ? base_work_reg : (base_work_reg % src_ptr);

  // AXI4-Lite slave; a write waits while a command executes
  wire do_wr = have_aw_q && have_w_q && !s_axi_bvalid && !exec_q;
  wire do_rd = s_axi_arvalid && !s_axi_rvalid;
  assign s_axi_awready = !have_aw_q && !s_axi_bvalid;
  assign s_axi_wready = !have_w_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  wire wr_is_w = (aw_addr_q[`ACS_WORK_REGION] == `ACS_WORK_BASE);
  wire wr_is_m = (aw_addr_q[`ACS_MEM_REGION] == `ACS_MEM_BASE);
  wire wr_is_reg = (aw_addr_q == `ACS_OFF_CMD) || (aw_addr_q == `ACS_OFF_OPND) ||
                   (aw_addr_q == `ACS_OFF_STAT) || (aw_addr_q == `ACS_OFF_ACCA_LO) ||
                   (aw_addr_q == `ACS_OFF_ACCA_HI) || (aw_addr_q == `ACS_OFF_ACCB_LO) ||
                   (aw_addr_q == `ACS_OFF_ACCB_HI);
  wire [15:0] w_old = w_q[aw_addr_q[`ACS_WORK_IDX]];
  wire [15:0] m_old = mem_q[aw_addr_q[`ACS_MEM_IDX]];
  wire [31:0] w_mrg = acs_merge({16'h0000, w_old}, w_data_q, w_strb_q);
  wire [31:0] m_mrg = acs_merge({16'h0000, m_old}, w_data_q, w_strb_q);
  wire [31:0] stat_word = {20'h00000, dsp_q, 3'h0, mcu_q};
  wire [31:0] stat_mrg = acs_merge(stat_word, w_data_q, w_strb_q);

  reg [31:0] rd_mux;
  reg rd_ok;
  always @* begin
    rd_ok = 1'b1;
    rd_mux = 32'h00000000;
    if (s_axi_araddr[`ACS_WORK_REGION] == `ACS_WORK_BASE) begin
      rd_mux = {16'h0000, w_q[s_axi_araddr[`ACS_WORK_IDX]]};
    end else if (s_axi_araddr[`ACS_MEM_REGION] == `ACS_MEM_BASE) begin
      rd_mux = {16'h0000, mem_q[s_axi_araddr[`ACS_MEM_IDX]]};
    end else begin
      case (s_axi_araddr)
        `ACS_OFF_CMD: rd_mux = cmd_q;
        `ACS_OFF_OPND: rd_mux = opnd_q;
        `ACS_OFF_STAT: rd_mux = stat_word;
        `ACS_OFF_ACCA_LO: rd_mux = acca_q[31:0];
        `ACS_OFF_ACCA_HI: rd_mux = {24'h000000, acca_q[39:32]};
        `ACS_OFF_ACCB_LO: rd_mux = accb_q[31:0];
        `ACS_OFF_ACCB_HI: rd_mux = {24'h000000, accb_q[39:32]};
        `ACS_OFF_PROD: rd_mux = prod_q;
        default: rd_ok = 1'b0;
      endcase
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      for (i = 0; i < 16; i = i + 1) begin
        w_q[i] <= 16'h0000;
      end
      cmd_q <= 32'h00000000;
      opnd_q <= 32'h00000000;
      mcu_q <= 5'h00;
      dsp_q <= 4'h0;
      acca_q <= 40'h0000000000;
      accb_q <= 40'h0000000000;
      prod_q <= 32'h00000000;
      exec_q <= 1'b0;
      op_done <= 1'b0;
      have_aw_q <= 1'b0;
      have_w_q <= 1'b0;
      aw_addr_q <= 12'h000;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `ACS_RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `ACS_RESP_OKAY;
      s_axi_rdata <= 32'h00000000;
    end else begin
      op_done <= exec_q;
      exec_q <= 1'b0;
      if (s_axi_awvalid && s_axi_awready) begin
        have_aw_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        have_w_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (do_wr) begin
        have_aw_q <= 1'b0;
        have_w_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wr_is_w || wr_is_m || wr_is_reg) ? `ACS_RESP_OKAY : `ACS_RESP_SLVERR;
        if (wr_is_w) begin
          w_q[aw_addr_q[`ACS_WORK_IDX]] <= w_mrg[15:0];
        end
        if (wr_is_m) begin
          mem_q[aw_addr_q[`ACS_MEM_IDX]] <= m_mrg[15:0];
        end
        case (aw_addr_q)
          `ACS_OFF_CMD: begin
            cmd_q <= acs_merge(cmd_q, w_data_q, w_strb_q);
            exec_q <= 1'b1;
          end
          `ACS_OFF_OPND: opnd_q <= acs_merge(opnd_q, w_data_q, w_strb_q);
          `ACS_OFF_STAT: begin
            mcu_q <= stat_mrg[`ACS_ST_MCU];
            dsp_q <= stat_mrg[`ACS_ST_DSP];
          end
          `ACS_OFF_ACCA_LO: acca_q[31:0] <= acs_merge(acca_q[31:0], w_data_q, w_strb_q);
          `ACS_OFF_ACCA_HI: acca_q[39:32] <= w_strb_q[0] ? w_data_q[7:0] : acca_q[39:32];
          `ACS_OFF_ACCB_LO: accb_q[31:0] <= acs_merge(accb_q[31:0], w_data_q, w_strb_q);
          `ACS_OFF_ACCB_HI: accb_q[39:32] <= w_strb_q[0] ? w_data_q[7:0] : accb_q[39:32];
          default: ;
        endcase
      end
      if (do_rd) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_ok ? `ACS_RESP_OKAY : `ACS_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      // Execution never overlaps a bus write, so the flags see no write race
      if (exec_q) begin
        mcu_q <= (mcu_q & ~fl_mask) | (fl_new & fl_mask);
        case (op)
          `ACS_CADD_F, `ACS_AND_F, `ACS_ASR_F: begin
            if (to_w0) begin
              w_q[`ACS_W_Q] <= res;
            end else begin
              mem_q[f_i] <= res;
            end
          end
          `ACS_CADD_LIT, `ACS_AND_LIT, `ACS_ASR_M: begin
            w_q[dst_i] <= res;
          end
          `ACS_CADD_W, `ACS_AND_W, `ACS_ASR_W: begin
            w_q[src_i] <= acs_amod(smode, src_ptr);
            if (dmode == `ACS_AM_DIRECT) begin
              w_q[dst_i] <= res;
            end else begin
              w_q[dst_i] <= acs_amod(dmode, dest_ptr);
              mem_q[dest_ptr[`ACS_WIDX]] <= res;
            end
          end
          `ACS_ADD_ACC: begin
            w_q[src_i] <= acs_amod(smode, src_ptr);
            if (acc_b) begin
              accb_q <= acc_res;
              dsp_q[`ACS_D_OVB] <= acc_oa;
              dsp_q[`ACS_D_SATB] <= dsp_q[`ACS_D_SATB] | acc_ovf;
            end else begin
              acca_q <= acc_res;
              dsp_q[`ACS_D_OVA] <= acc_oa;
              dsp_q[`ACS_D_SATA] <= dsp_q[`ACS_D_SATA] | acc_ovf;
            end
          end
          `ACS_MPY, `ACS_SQR: begin
            if (pair_ok) begin
              prod_q <= prod;
              if (acc_b) begin
                accb_q <= {{8{prod[31]}}, prod};
              end else begin
                acca_q <= {{8{prod[31]}}, prod};
              end
              if (x_on) begin
                w_q[x_ptr_i] <= x_next;
                w_q[{`ACS_MUL_HI, xd}] <= x_data;
              end
              if (y_on) begin
                w_q[y_ptr_i] <= y_next;
                w_q[{`ACS_MUL_HI, yd}] <= y_data;
              end
            end
          end
          `ACS_DIV: begin
            w_q[`ACS_W_Q] <= dv_q;
            w_q[`ACS_W_R] <= dv_r;
          end
          default: ;
        endcase
      end
    end
  end
endmodule // acs_datapath
`default_nettype wire

//--- verilog/acs_defs.vh
/*
  Constants for the add / carry / shift operand datapath: register map,
  command and operand field layouts, opcodes, flag positions and masks.
  Assumes an AXI4-Lite master with a 12-bit byte address and 32-bit data.
*/
// What this block does
// - Sixteen working registers, any usable as base, source or destination.
// - Register 0 is the implicit second operand and optional result of file forms.
// - Square takes one of registers 4 to 7 multiplied by itself.
// - Multiply takes one of six distinct pairs from registers 4 to 7.
// - X prefetch address from register 8 or 9, with post-modify or indexed modes.
// - Y prefetch address from register 10 or 11, with post-modify or indexed modes.
// - X prefetch data lands in one of registers 4 to 7.
// - Y prefetch data lands in one of registers 4 to 7, chosen independently.
// - Divide reads dividend and divisor from two directly addressed registers.
// - Signed add of shifted 16-bit source into accumulator; only its overflow/saturate flags.
// - File add-with-carry sums file word, register 0 and carry; updates all five flags.
// - Literal add-with-carry adds 10-bit literal and carry to a register; five flags.
// - File arithmetic right shift by one keeps sign; updates carry, negative, overflow, zero.
// - Register arithmetic right shift with addressing modes; carry, negative, overflow, zero.
// - Multi-bit arithmetic right shift by register count; only negative and zero change.
// - Status holds carry, digit carry, negative, overflow and zero flags.
// - DSP status holds overflow and saturate flags per accumulator.
`ifndef ACS_DEFS_VH
`define ACS_DEFS_VH

`define ACS_AW 12
`define ACS_OFF_CMD 12'h000
`define ACS_OFF_OPND 12'h004
`define ACS_OFF_STAT 12'h008
`define ACS_OFF_ACCA_LO 12'h00C
`define ACS_OFF_ACCA_HI 12'h010
`define ACS_OFF_ACCB_LO 12'h014
`define ACS_OFF_ACCB_HI 12'h018
`define ACS_OFF_PROD 12'h01C
`define ACS_WORK_REGION 11:6
`define ACS_WORK_BASE 6'h01
`define ACS_WORK_IDX 5:2
`define ACS_MEM_REGION 11:8
`define ACS_MEM_BASE 4'h1
`define ACS_MEM_IDX 7:2

`define ACS_RESP_OKAY 2'h0
`define ACS_RESP_SLVERR 2'h2

`define ACS_CMD_OP 4:0
`define ACS_CMD_DST 8:5
`define ACS_CMD_SRC 12:9
`define ACS_CMD_BASE 16:13
`define ACS_CMD_TOW0 17
`define ACS_CMD_ACCB 18
`define ACS_CMD_SMODE 20:19
`define ACS_CMD_DMODE 22:21
`define ACS_CMD_F 28:23

`define ACS_OP_LIT 9:0
`define ACS_OP_SHIFT 13:10
`define ACS_OP_PAIR 16:14
`define ACS_OP_SQR 18:17
`define ACS_OP_XMODE 22:19
`define ACS_OP_XD 24:23
`define ACS_OP_YMODE 28:25
`define ACS_OP_YD 30:29
`define ACS_OP_SATEN 31

`define ACS_NOP 5'h00
`define ACS_CADD_F 5'h01
`define ACS_CADD_LIT 5'h02
`define ACS_CADD_W 5'h03
`define ACS_ADD_ACC 5'h04
`define ACS_ASR_F 5'h05
`define ACS_ASR_W 5'h06
`define ACS_ASR_M 5'h07
`define ACS_AND_F 5'h08
`define ACS_AND_LIT 5'h09
`define ACS_AND_W 5'h0A
`define ACS_MPY 5'h0B
`define ACS_SQR 5'h0C
`define ACS_DIV 5'h0D

`define ACS_AM_DIRECT 2'h0
`define ACS_AM_POSTINC 2'h2
`define ACS_AM_POSTDEC 2'h3
`define ACS_WORD_STEP 16'h0002
`define ACS_WIDX 6:1
`define ACS_SHCNT 3:0

`define ACS_PF_P2 16'h0002
`define ACS_PF_P4 16'h0004
`define ACS_PF_P6 16'h0006
`define ACS_PF_M2 16'hFFFE
`define ACS_PF_M4 16'hFFFC
`define ACS_PF_M6 16'hFFFA
`define ACS_W_X0 4'h8
`define ACS_W_X1 4'h9
`define ACS_W_Y0 4'hA
`define ACS_W_Y1 4'hB
`define ACS_W_IDX 4'hC
`define ACS_W_Q 4'h0
`define ACS_W_R 4'h1
`define ACS_MUL_HI 2'h1

`define ACS_FL_C 0
`define ACS_FL_DC 1
`define ACS_FL_N 2
`define ACS_FL_OV 3
`define ACS_FL_Z 4
`define ACS_FM_ALL 5'h1F
`define ACS_FM_ASR 5'h1D
`define ACS_FM_NZ 5'h14
`define ACS_FM_NONE 5'h00
`define ACS_D_OVA 0
`define ACS_D_OVB 1
`define ACS_D_SATA 2
`define ACS_D_SATB 3
`define ACS_ST_MCU 4:0
`define ACS_ST_DSP 11:8

`define ACS_ACC_MAX 40'h7FFFFFFFFF
`define ACS_ACC_MIN 40'h8000000000
`define ACS_DIV0_Q 16'hFFFF

`endif
